// ===== verilog/nibble_xor_exec.sv
/*
 * execution slice for nibble swap, literal xor, register xor and port
 * direction load. one instruction word is presented per clock; the file
 * register value for the word's address arrives combinationally on
 * FILE_RDATA_I. results land on the next edge.
 */
// Overview of operation
// [RULE1] nibble swap exchanges high and low nibbles of f; flags untouched
// [RULE2] nibble swap result goes to accumulator if d is 0, else back to f
// [RULE3] direction load copies accumulator into selected direction register
// [RULE4] direction load accepts selectors 5 through 9, others ignored; the 3-bit field here reaches only 5 through 7
// [RULE5] literal xor puts accumulator xor literal in accumulator, updates zero
// [RULE6] register xor computes accumulator xor f; zero set when result zero
// [RULE7] register xor result goes to accumulator if d is 0, else back to f
// [RULE8] each instruction is one word, done in one cycle, visible next one
`timescale 1ns/1ps
module nibble_xor_exec
    import nibble_xor_pkg::*;
(
    input  wire logic                         CLOCK_I,
    input  wire logic                         RST_B_I,
    input  wire logic                         INSTR_VALID_I,
    input  wire logic [WORD_W-1:0]            INSTR_I,
    input  wire logic [DATA_W-1:0]            FILE_RDATA_I,
    output logic      [FADDR_W-1:0]           FILE_RADDR_O,
    output file_wr_t                          FILE_WR_O,
    output logic      [DATA_W-1:0]            ACC_O,
    output logic                              ZERO_O,
    output logic      [NUM_DIRREG*DATA_W-1:0] DIRREG_O,
    output logic                              ILLEGAL_O
);

    exec_state_t state_q;
    exec_state_t state_d;
    op_kind_t    op;
    logic        dir_ok;
    logic [DATA_W-1:0] swapped;
    logic [DATA_W-1:0] xored;
    logic [3:0]  sel;

    function automatic op_kind_t decode(input logic [WORD_W-1:0] w);
        // bit 5 is the direction bit, so it stays out of the swap and register xor opcode match
        if (w[11:6] == SWAP_PAT)
            return OP_SWAP;
        else if (w[11:6] == REGXOR_PAT)
            return OP_REGXOR;
        else if (w[11:8] == LITXOR_PAT)
            return OP_LITXOR;
        else if (w[11:3] == DIRLOAD_PAT && w[2:0] >= DIRLOAD_MIN)
            return OP_DIRLOAD;
        else
            return OP_NONE;
    endfunction : decode

    // the three-bit selector field cannot encode 8 or 9 in a 12-bit word,
    // so those selectors are honoured only if decode widens the field
    assign sel     = {1'b0, INSTR_I[2:0]};
    assign op      = INSTR_VALID_I ? decode(INSTR_I) : OP_NONE;
    assign dir_ok  = (sel >= {1'b0, DIRLOAD_MIN}) && (sel <= DIRLOAD_MAX); // [RULE4]
    assign FILE_RADDR_O = INSTR_I[FADDR_W-1:0];
    assign swapped = {FILE_RDATA_I[3:0], FILE_RDATA_I[7:4]};       // [RULE1]
    assign xored   = state_q.acc ^ (op == OP_LITXOR ? INSTR_I[7:0]
                                                    : FILE_RDATA_I);

    always_comb
    begin
        state_d         = state_q;
        state_d.fwr     = '{we: 1'b0, addr: INSTR_I[FADDR_W-1:0],
                            data: '0};
        state_d.last_op = op;
        unique case (op)
            OP_SWAP:
            begin
                if (INSTR_I[DIR_BIT])                               // [RULE2]
                begin
                    state_d.fwr.we   = 1'b1;
                    state_d.fwr.data = swapped;
                end
                else
                begin
                    state_d.acc = swapped;                          // [RULE2]
                end
            end
            OP_LITXOR:
            begin
                state_d.acc  = xored;                               // [RULE5]
                state_d.zero = (xored == '0);                       // [RULE5]
            end
            OP_REGXOR:
            begin
                state_d.zero = (xored == '0);                       // [RULE6]
                if (INSTR_I[DIR_BIT])                               // [RULE7]
                begin
                    state_d.fwr.we   = 1'b1;
                    state_d.fwr.data = xored;
                end
                else
                begin
                    state_d.acc = xored;                            // [RULE7]
                end
            end
            OP_DIRLOAD:
            begin
                if (dir_ok)                                         // [RULE3]
                    state_d.dirreg[(32'(sel) - 32'(DIRLOAD_MIN))*DATA_W
                                   +: DATA_W] = state_q.acc;
            end
            OP_NONE:
            begin
            end
        endcase
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_B_I)
        begin
            state_q.acc     <= ACC_RESET;
            state_q.zero    <= 1'b0;
            state_q.dirreg  <= {NUM_DIRREG{DIRREG_RESET}};
            state_q.fwr     <= '0;
            state_q.last_op <= OP_NONE;
        end
        else
        begin
            state_q <= state_d;                                     // [RULE8]
        end
    end

    assign FILE_WR_O = state_q.fwr;
    assign ACC_O     = state_q.acc;
    assign ZERO_O    = state_q.zero;
    assign DIRREG_O  = state_q.dirreg;
    assign ILLEGAL_O = INSTR_VALID_I && (op == OP_NONE);

    chk_swap_nibbles: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_SWAP && !INSTR_I[DIR_BIT] |=>
        ACC_O == {$past(FILE_RDATA_I[3:0]), $past(FILE_RDATA_I[7:4])}) // [RULE1]
        else $error("swap result wrong");
    chk_swap_flags: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_SWAP |=> $stable(ZERO_O)) // [RULE1]
        else $error("swap changed zero flag");
    chk_swap_dest: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_SWAP && INSTR_I[DIR_BIT] |=>
        FILE_WR_O.we && $stable(ACC_O)) // [RULE2]
        else $error("swap to file missed");
    chk_dir_load: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_DIRLOAD && INSTR_I[2:0] == 3'h6 |=>
        DIRREG_O[15:8] == $past(ACC_O)) // [RULE3]
        else $error("direction load wrong");
    chk_dir_range: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        INSTR_VALID_I && INSTR_I[11:3] == 9'h000 && INSTR_I[2:0] < 3'h5
        |=> $stable(DIRREG_O)) // [RULE4]
        else $error("bad selector loaded");
    chk_lit_xor: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_LITXOR |=> ACC_O == ($past(ACC_O) ^ $past(INSTR_I[7:0]))
        && ZERO_O == (ACC_O == 8'h00)) // [RULE5]
        else $error("literal xor wrong");
    chk_reg_xor_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_REGXOR |=>
        ZERO_O == ($past(ACC_O) == $past(FILE_RDATA_I))) // [RULE6]
        else $error("register xor zero wrong");
    chk_reg_xor_dest: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_REGXOR && INSTR_I[DIR_BIT] |=>
        FILE_WR_O.we && FILE_WR_O.data == ($past(ACC_O) ^ $past(FILE_RDATA_I))
        && $stable(ACC_O)) // [RULE7]
        else $error("register xor to file wrong");
    chk_one_cycle: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_NONE |=> !FILE_WR_O.we) // [RULE8]
        else $error("write without instruction");

    // these pin down what each instruction must write or leave untouched, so a decode
    // slip that fires the wrong branch shows up one cycle later
    chk_swap_file_data: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        op == OP_SWAP && INSTR_I[DIR_BIT] |=>
        FILE_WR_O.addr == $past(INSTR_I[FADDR_W-1:0])
        && FILE_WR_O.data == {$past(FILE_RDATA_I[3:0]),
                              $past(FILE_RDATA_I[7:4])}) // [RULE2]
        else $error("swap write-back wrong");
    chk_reg_xor_acc: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        op == OP_REGXOR && !INSTR_I[DIR_BIT] |=>
        ACC_O == ($past(ACC_O) ^ $past(FILE_RDATA_I))
        && !FILE_WR_O.we) // [RULE7]
        else $error("register xor to accumulator wrong");
    chk_lit_xor_only: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        op == OP_LITXOR |=> !FILE_WR_O.we && $stable(DIRREG_O)) // [RULE5]
        else $error("literal xor touched other state");
    chk_dir_no_flags: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        op == OP_DIRLOAD |=>
        $stable(ACC_O) && $stable(ZERO_O) && !FILE_WR_O.we) // [RULE3]
        else $error("direction load touched other state");
    chk_dir_slot_five: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        op == OP_DIRLOAD && INSTR_I[2:0] == 3'h5 |=>
        DIRREG_O[DATA_W-1:0] == $past(ACC_O)
        && $stable(DIRREG_O[NUM_DIRREG*DATA_W-1:DATA_W])) // [RULE3]
        else $error("direction load hit wrong slot");
    chk_refused_idle: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        ILLEGAL_O |=>
        $stable(ACC_O) && $stable(ZERO_O) && $stable(DIRREG_O)
        && !FILE_WR_O.we) // [RULE4]
        else $error("refused word changed state");
    // last_op is kept only so that a write-back pulse can be traced to the
    // instruction that caused it
    chk_write_source: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        FILE_WR_O.we |->
        state_q.last_op inside {OP_SWAP, OP_REGXOR}) // [RULE8]
        else $error("write-back from wrong instruction");
    // no disable here: the values held in reset are what is checked
    chk_reset_values: assert property (@(posedge CLOCK_I)
        !RST_B_I |=>
        ACC_O == ACC_RESET && !ZERO_O && !FILE_WR_O.we
        && DIRREG_O == {NUM_DIRREG{DIRREG_RESET}})
        else $error("reset values wrong");

    cov_swap_f:   cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_SWAP && INSTR_I[DIR_BIT]);
    cov_lit_zero: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_LITXOR ##1 ZERO_O);
    cov_reg_w:    cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_REGXOR && !INSTR_I[DIR_BIT]);
    cov_dir_7:    cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        op == OP_DIRLOAD && INSTR_I[2:0] == 3'h7);
    cov_dir_low:  cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        INSTR_VALID_I && INSTR_I[11:3] == 9'h000 && INSTR_I[2:0] < 3'h5);

endmodule : nibble_xor_exec

// ===== verilog/nibble_xor_pkg.sv
/*
 * constants and carrier types for the four-instruction execution slice:
 * opcode patterns, field positions, reset values and port selector range.
 * assumes 12-bit program words and an 8-bit data path.
 */
package nibble_xor_pkg;

    localparam int          WORD_W        = 12;
    localparam int          DATA_W        = 8;
    localparam int          FADDR_W       = 5;
    localparam int          DIR_BIT       = 5;
    // upper six bits select swap / register xor; upper four the literal xor
    localparam logic [5:0]  SWAP_PAT      = 6'h0e;
    localparam logic [5:0]  REGXOR_PAT    = 6'h06;
    localparam logic [3:0]  LITXOR_PAT    = 4'hf;
    // direction load word is 0000 0000 0fff
    localparam logic [8:0]  DIRLOAD_PAT   = 9'h000;
    localparam logic [2:0]  DIRLOAD_MIN   = 3'h5;
    localparam logic [3:0]  DIRLOAD_MAX   = 4'h9;
    localparam int          NUM_DIRREG    = 5;
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic [7:0]  DIRREG_RESET  = 8'hff;
    localparam int          EXEC_CYCLES   = 1;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SWAP,
        OP_LITXOR,
        OP_REGXOR,
        OP_DIRLOAD
    } op_kind_t;

    typedef struct packed {
        logic                 we;
        logic [FADDR_W-1:0]   addr;
        logic [DATA_W-1:0]    data;
    } file_wr_t;

    typedef struct packed {
        logic [DATA_W-1:0]              acc;
        logic                           zero;
        logic [NUM_DIRREG*DATA_W-1:0]   dirreg;
        file_wr_t                       fwr;
        op_kind_t                       last_op;
    } exec_state_t;

endpackage : nibble_xor_pkg

// ===== sim/tb_top.sv
/*
 * self-checking bench for the four-instruction execution slice.
 * assumes the file register value is served combinationally by the bench.
 */
`timescale 1ns/1ps
module tb_top;
    import nibble_xor_pkg::*;
    logic                         clock_i = 1'b0;
    logic                         rst_b_i = 1'b0;
    logic                         instr_valid_i = 1'b0;
    logic [WORD_W-1:0]            instr_i = '0;
    logic [DATA_W-1:0]            file_rdata_i = '0;
    logic [FADDR_W-1:0]           raddr;
    file_wr_t                     fwr;
    logic [DATA_W-1:0]            acc;
    logic                         zero;
    logic [NUM_DIRREG*DATA_W-1:0] dirreg;
    logic                         illegal;
    int                           n_mismatch = 0;
    int                           compares = 0;

    nibble_xor_exec i_dut (.CLOCK_I(clock_i), .RST_B_I(rst_b_i),
        .INSTR_VALID_I(instr_valid_i), .INSTR_I(instr_i),
        .FILE_RDATA_I(file_rdata_i), .FILE_RADDR_O(raddr),
        .FILE_WR_O(fwr), .ACC_O(acc), .ZERO_O(zero),
        .DIRREG_O(dirreg), .ILLEGAL_O(illegal));

    always #20 clock_i = ~clock_i;

    task automatic cmp_byte(string what, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_byte

    task automatic cmp_bit(string what, logic e, logic g);
        cmp_byte(what, {7'h00, e}, {7'h00, g});
    endtask : cmp_bit

    task automatic cmp_wr(file_wr_t e);
        cmp_byte("write enable", {7'h00, e.we}, {7'h00, fwr.we});
        if (e.we)
        begin
            cmp_byte("write addr", {3'h0, e.addr}, {3'h0, fwr.addr});
            cmp_byte("write data", e.data, fwr.data);
        end
    endtask : cmp_wr

    // word stays valid until the next call, so calls run back to back
    task automatic exec(logic [11:0] w, logic [7:0] rd);
        @(negedge clock_i);
        instr_valid_i = 1'b1;
        instr_i = w;
        file_rdata_i = rd;
        @(posedge clock_i);
        #1;
    endtask : exec

    task automatic test_reset;
        cmp_byte("acc", 8'h00, acc);
        cmp_bit("zero", 1'b0, zero);
        cmp_wr('0);
        for (int i = 0; i < NUM_DIRREG; i++)
            cmp_byte("dirreg", 8'hff, dirreg[i*8 +: 8]);
        $display("test reset done");
    endtask : test_reset

    task automatic test_litxor;
        exec(12'hfb5, 8'h00);
        cmp_byte("acc", 8'hb5, acc);
        exec(12'hfaf, 8'h00);
        cmp_byte("acc", 8'h1a, acc);
        cmp_bit("zero", 1'b0, zero);
        exec(12'hf1a, 8'h00);
        cmp_bit("zero", 1'b1, zero);
        $display("test literal xor done");
    endtask : test_litxor

    task automatic test_swap;
        exec(12'h385, 8'ha5);
        cmp_byte("raddr", 8'h05, {3'h0, raddr});
        cmp_byte("acc", 8'h5a, acc);
        cmp_bit("zero", 1'b1, zero);
        exec(12'h3b3, 8'h3c);
        cmp_wr('{1'b1, 5'h13, 8'hc3});
        cmp_bit("illegal", 1'b0, illegal);
        cmp_byte("acc", 8'h5a, acc);
        $display("test swap done");
    endtask : test_swap

    task automatic test_regxor;
        exec(12'hf66, 8'h00);
        cmp_wr('0);
        exec(12'h1be, 8'h3c);
        cmp_wr('{1'b1, 5'h1e, 8'h00});
        cmp_bit("illegal", 1'b0, illegal);
        cmp_bit("zero", 1'b1, zero);
        cmp_byte("acc", 8'h3c, acc);
        exec(12'h185, 8'h5a);
        cmp_byte("acc", 8'h66, acc);
        cmp_bit("zero", 1'b0, zero);
        $display("test register xor done");
    endtask : test_regxor

    task automatic test_dirload;
        logic [7:0] e;
        e = 8'h66;
        for (int s = 5; s <= 7; s++)
        begin
            exec({4'hf, 8'(s * 17)}, 8'h00);
            e = e ^ 8'(s * 17);
            exec({9'h000, 3'(s)}, 8'h00);
            cmp_byte("dirreg", e, dirreg[(s-5)*8 +: 8]);
            cmp_bit("illegal", 1'b0, illegal);
        end
        exec(12'h004, 8'h00);
        cmp_byte("dirreg", 8'hff, dirreg[24 +: 8]);
        cmp_byte("dirreg", 8'h33, dirreg[0 +: 8]);
        cmp_byte("acc", e, acc);
        exec(12'h0f0, 8'h00);
        cmp_bit("illegal", 1'b1, illegal);
        cmp_byte("dirreg", 8'hff, dirreg[32 +: 8]);
        $display("test direction load done");
    endtask : test_dirload

    task automatic test_mid_reset;
        @(negedge clock_i);
        rst_b_i = 1'b0;
        @(negedge clock_i);
        rst_b_i = 1'b1;
        cmp_byte("acc", 8'h00, acc);
        cmp_bit("zero", 1'b0, zero);
        cmp_wr('0);
        cmp_byte("dirreg", 8'hff, dirreg[16 +: 8]);
        exec(12'hf01, 8'h00);
        cmp_byte("acc", 8'h01, acc);
        $display("test mid reset done");
    endtask : test_mid_reset

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    initial
    begin
        #(40 * 500);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        repeat (4) @(negedge clock_i);
        rst_b_i = 1'b1;
        test_reset();
        test_litxor();
        test_swap();
        test_regxor();
        test_dirload();
        test_mid_reset();
        @(negedge clock_i);
        instr_valid_i = 1'b0;
        finish_test();
    end
endmodule : tb_top
